// ---- core/clrb_chan.sv ----
// One counter channel's hold register, status hold and byte pointer
`timescale 1ns/1ns
`default_nettype none
module clrb_chan
(
  input  wire logic        clock_in,      // System clock
  input  wire logic        sys_rst_in,    // Sync reset, high
  input  wire logic        ctl_wr_in,     // Control word for this channel
  input  wire logic [5:0]  ctl_cfg_in,    // Access, mode, format bits
  input  wire logic        latch_cnt_in,  // Count latch request
  input  wire logic        latch_sta_in,  // Status latch request
  input  wire logic        rd_in,         // Data read strobe
  input  wire logic        wr_in,         // Data write strobe
  input  wire logic [15:0] count_in,      // Live count
  input  wire logic        out_in,        // Counter output level
  input  wire logic        null_in,       // Null count flag
  output logic [7:0]       rd_data_out,   // Byte for this read
  output logic [5:0]       cfg_out,       // Stored config
  output logic             ptr_hi_out     // Byte pointer at high byte
);
  typedef struct packed {
    logic [1:0]  acc;
    logic [2:0]  mode;
    logic        fmt;
    logic        ptr_hi;
    logic        cnt_held;
    logic [15:0] hold;
    logic        sta_held;
    logic [7:0]  status_latch_n;
    logic [7:0]  rd_data;
  } clrb_chan_st_t;
  clrb_chan_st_t st_r;
  clrb_chan_st_t st_nxt;
  logic [7:0] hi_b;
  logic [7:0] lo_b;
  logic       last_b;
  // Next state of the channel
  always_comb
  begin
    st_nxt = st_r;
    hi_b = st_r.cnt_held ? st_r.hold[15:8] : count_in[15:8];
    lo_b = st_r.cnt_held ? st_r.hold[7:0] : count_in[7:0];
    last_b = (st_r.acc != clrb_pkg::ACC_PAIR) || st_r.ptr_hi;
    if (ctl_wr_in)
    begin
      st_nxt.acc = ctl_cfg_in[5:4];
      st_nxt.mode = ctl_cfg_in[3:1];
      st_nxt.fmt = ctl_cfg_in[0];
      st_nxt.ptr_hi = 1'b0;
    end
    if (rd_in)
    begin
      if (st_r.sta_held)
      begin
        st_nxt.rd_data = st_r.status_latch_n;
        st_nxt.sta_held = 1'b0;
      end
      else
      begin
        st_nxt.rd_data = (st_r.acc == clrb_pkg::ACC_HI ||
                          (st_r.acc == clrb_pkg::ACC_PAIR && st_r.ptr_hi)) ? hi_b : lo_b;
        if (st_r.acc == clrb_pkg::ACC_PAIR)
          st_nxt.ptr_hi = ~st_r.ptr_hi;
        if (last_b)
          st_nxt.cnt_held = 1'b0;
      end
    end
    else if (wr_in && st_r.acc == clrb_pkg::ACC_PAIR)
      st_nxt.ptr_hi = ~st_r.ptr_hi;
    if (latch_cnt_in && !st_r.cnt_held)
    begin
      st_nxt.cnt_held = 1'b1;
      st_nxt.hold = count_in;
    end
    if (latch_sta_in && !st_r.sta_held)
    begin
      st_nxt.sta_held = 1'b1;
      st_nxt.status_latch_n = {out_in, null_in, st_r.acc, st_r.mode, st_r.fmt};
    end
    if (sys_rst_in)
    begin
      st_nxt = '0;
      st_nxt.acc = clrb_pkg::ACC_RESET;
      st_nxt.mode = clrb_pkg::MODE_RESET;
    end
  end
  // State register
  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end
  assign rd_data_out = st_r.rd_data;
  assign cfg_out = {st_r.acc, st_r.mode, st_r.fmt};
  assign ptr_hi_out = st_r.ptr_hi;
endmodule : clrb_chan
`default_nettype wire

// ---- core/clrb_pkg.sv ----
// Constants for the counter latch and readback read path
package clrb_pkg;
  // Control byte fields
  localparam int CTL_SEL_MSB = 7;
  localparam int CTL_SEL_LSB = 6;
  localparam int CTL_ACC_MSB = 5;
  localparam int CTL_ACC_LSB = 4;
  localparam int CTL_MODE_MSB = 3;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_FMT_BIT = 0;
  // Readback command fields
  localparam int RB_CNT_BIT = 5;
  localparam int RB_STA_BIT = 4;
  localparam int RB_SEL_MSB = 3;
  localparam int RB_SEL_LSB = 1;
  // Status byte fields
  localparam int ST_OUT_BIT = 7;
  localparam int ST_NULL_BIT = 6;
  // Encodings
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO = 2'h1;
  localparam logic [1:0] ACC_HI = 2'h2;
  localparam logic [1:0] ACC_PAIR = 2'h3;
  // Reset values
  localparam logic [1:0] ACC_RESET = 2'h3;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam int NUM_CNT = 3;
endpackage : clrb_pkg

// ---- core/clrb_top.sv ----
// Read path of a three-channel down counter: latch, byte access, readback
// Overview of operation
// - Control byte with access bits zero latches selected count into hold register.
// - Each counter keeps access mode: high only, low only, or low then high.
// - Two-byte mode alternates byte pointer; host accesses in low-high pairs.
// - Select 11 and bit 0 clear decodes readback; bits 5,4 latch requests.
// - Readback count bit low latches all selected counters same cycle.
// - Readback status bit low captures status byte for next data read.
// - Status byte: output, null count, access mode, mode, number format.
// - Null count flag shows written count not yet in counting element.
// - Status and count latched in pair mode read status, low, high.
// - Further latches ignored until hold register fully read.
// - Status latched over unread count is returned first.
// - Control byte: select, access mode, mode, number format fields.
`timescale 1ns/1ns
`default_nettype none
module clrb_top
(
  input  wire logic        clock_in,       // System clock, 250 MHz
  input  wire logic        sys_rst_in,     // Sync reset, high
  input  wire logic        ctl_wr_in,      // Control byte write strobe
  input  wire logic [7:0]  ctl_data_in,    // Control or readback byte
  input  wire logic [1:0]  cnt_idx_in,     // Counter data location
  input  wire logic        cnt_rd_in,      // Counter data read strobe
  input  wire logic        cnt_wr_in,      // Counter data write strobe
  input  wire logic [47:0] count_in,       // Live counts, 16 bits each
  input  wire logic [2:0]  cnt_out_in,     // Counter output levels
  input  wire logic [2:0]  null_count_in,  // Null count flags
  output logic [7:0]       rd_data_out,    // Read byte, one cycle after read
  output logic [17:0]      cfg_out,        // Per-counter config, 6 bits each
  output logic [2:0]       ptr_hi_out      // Per-counter byte pointer
);
  logic [1:0] sel;
  logic       is_rb;
  logic       is_ctl;
  logic [2:0] rb_sel;
  logic [1:0] acc;
  logic [7:0] rd_bytes [0:3];
  // Registered state of the read mux
  typedef struct packed {
    logic [1:0] rd_idx;
  } clrb_top_st_t;
  clrb_top_st_t st_r;
  clrb_top_st_t st_nxt;
  // Control byte decode
  // control fields
  assign sel = ctl_data_in[clrb_pkg::CTL_SEL_MSB:clrb_pkg::CTL_SEL_LSB];
  assign acc = ctl_data_in[clrb_pkg::CTL_ACC_MSB:clrb_pkg::CTL_ACC_LSB];
  assign is_rb = ctl_wr_in && sel == clrb_pkg::SEL_READBACK &&
                 !ctl_data_in[clrb_pkg::CTL_FMT_BIT];
  assign is_ctl = ctl_wr_in && sel != clrb_pkg::SEL_READBACK;
  assign rb_sel = ctl_data_in[clrb_pkg::RB_SEL_MSB:clrb_pkg::RB_SEL_LSB];
  // Per-channel latch and readback logic
  genvar g;
  generate
    for (g = 0; g < clrb_pkg::NUM_CNT; g++)
    begin : gen_ch
      logic own;
      logic lat_c;
      logic lat_s;
      assign own = is_ctl && sel == 2'(g);
      assign lat_c = (own && acc == clrb_pkg::ACC_LATCH) ||
                     (is_rb && rb_sel[g] && !ctl_data_in[clrb_pkg::RB_CNT_BIT]);
      assign lat_s = is_rb && rb_sel[g] && !ctl_data_in[clrb_pkg::RB_STA_BIT];
      clrb_chan u_ch
      (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .ctl_wr_in    (own && acc != clrb_pkg::ACC_LATCH),
        .ctl_cfg_in   (ctl_data_in[clrb_pkg::CTL_ACC_MSB:0]),
        .latch_cnt_in (lat_c),
        .latch_sta_in (lat_s),
        .rd_in        (cnt_rd_in && cnt_idx_in == 2'(g)),
        .wr_in        (cnt_wr_in && cnt_idx_in == 2'(g)),
        .count_in     (count_in[16*g +: 16]),
        .out_in       (cnt_out_in[g]),
        .null_in      (null_count_in[g]),
        .rd_data_out  (rd_bytes[g]),
        .cfg_out      (cfg_out[6*g +: 6]),
        .ptr_hi_out   (ptr_hi_out[g])
      );
    end
  endgenerate
  // Unmapped location reads as zero
  assign rd_bytes[3] = 8'h00;
  // Remember which location was read last, unmapped one too
  always_comb
  begin
    st_nxt = st_r;
    if (cnt_rd_in)
      st_nxt.rd_idx = cnt_idx_in;
    if (sys_rst_in)
      st_nxt = '0;
  end
  // State register
  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end
  // ordered bytes leave the channel register
  assign rd_data_out = rd_bytes[st_r.rd_idx];
endmodule : clrb_top
`default_nettype wire

// ---- sim/clrb_top_bench.sv ----
// Self-checking bench for the latch and readback read path
`timescale 1ns/1ns
`default_nettype none
module clrb_top_bench;
  logic        clk = 0, rst = 1, cw = 0, rd = 0, wr = 0;
  logic [7:0]  cd = 0, rdo;
  logic [1:0]  ix = 0;
  logic [47:0] cnt = 0, lat;
  logic [2:0]  ol = 0, nl = 0, ptr;
  logic [17:0] cfg;
  logic [5:0]  cm [3] = '{6'h30, 6'h30, 6'h30};
  int          miscompares = 0, n_tests = 0, cyc = 0, seed = 32'h79fc_2523;
  // Clock
  always #2 clk = ~clk;
  clrb_top clrb_top_i (.clock_in(clk), .sys_rst_in(rst), .ctl_wr_in(cw), .ctl_data_in(cd),
    .cnt_idx_in(ix), .cnt_rd_in(rd), .cnt_wr_in(wr), .count_in(cnt), .cnt_out_in(ol),
    .null_count_in(nl), .rd_data_out(rdo), .cfg_out(cfg), .ptr_hi_out(ptr));
  function automatic logic [7:0] by(int g, int h);
    return cnt[16*g+8*h +: 8];
  endfunction : by
  task automatic chk(logic [17:0] g, logic [17:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Bus cycles, one strobe per two edges
  task automatic ctl(logic [7:0] b);
    @(posedge clk);
    #1 cw = 1;
    cd = b;
    @(posedge clk);
    #1 cw = 0;
    if (b[7:6] != 2'h3 && b[5:4] != 2'h0)
      cm[b[7:6]] = b[5:0];
  endtask : ctl
  task automatic get(int g, logic [7:0] e);
    @(posedge clk);
    #1 ix = g[1:0];
    rd = 1;
    @(posedge clk);
    #1 rd = 0;
    chk(rdo, e);
  endtask : get
  task automatic wrp();
    @(posedge clk);
    #1 ix = 0;
    wr = 1;
    @(posedge clk);
    #1 wr = 0;
  endtask : wrp
  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard, the tests need about 210 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  // Main sequence
  initial
  begin
    int g, m, s;
    repeat (5) @(posedge clk);
    #1 rst = 0;
    chk(cfg, {3{6'h30}});
    for (g = 0; g < 3; g++)
      for (m = 1; m < 4; m++)
      begin
        // counts held still across direct reads
        cnt = 48'({$random(seed), $random(seed)});
        ctl({g[1:0], m[1:0], 4'($random(seed))});
        chk(cfg[6*g +: 6], cm[g]);
        if (m != 2) get(g, by(g, 0));
        if (m != 1) get(g, by(g, 1));
      end
    wrp();
    chk(ptr[0], 1'b1);
    wrp();
    $display("test access done");
    for (g = 0; g < 3; g++)
    begin
      ctl({g[1:0], 6'h00});
      lat = cnt;
      cnt = 48'({$random(seed), $random(seed)});
      ctl({g[1:0], 6'h00});
      get(g, lat[16*g +: 8]);
      get(g, lat[16*g+8 +: 8]);
      get(g, by(g, 0));
      get(g, by(g, 1));
    end
    $display("test latch done");
    ol = 3'($random(seed));
    nl = 3'($random(seed));
    ctl(8'hCF);
    get(0, by(0, 0));
    get(0, by(0, 1));
    for (s = 1; s < 8; s++)
    begin
      lat = cnt;
      ctl(8'hC0 | 8'(s << 1) | (s[0] ? 8'h10 : 8'h00));
      cnt = 48'({$random(seed), $random(seed)});
      for (g = 0; g < 3; g++)
      begin
        if (s[g] && !s[0]) get(g, {ol[g], nl[g], cm[g]});
        get(g, s[g] ? lat[16*g +: 8] : by(g, 0));
        get(g, s[g] ? lat[16*g+8 +: 8] : by(g, 1));
      end
    end
    $display("test readback done");
    ctl(8'h40);
    lat = cnt;
    cnt = 48'({$random(seed), $random(seed)});
    ctl(8'hC4);
    get(1, {ol[1], nl[1], cm[1]});
    get(1, lat[23:16]);
    get(1, lat[31:24]);
    get(3, 8'h00);
    $display("test status order done");
    tally_and_finish;
  end
endmodule : clrb_top_bench
`default_nettype wire

// ---- sim/clrb_top_properties.sv ----
// Port checker for the latch and readback read path
`timescale 1ns/1ns
`default_nettype none
module clrb_top_properties
(
  input wire logic        clock_in,      // Clock
  input wire logic        sys_rst_in,    // Reset
  input wire logic        ctl_wr_in,     // Control write
  input wire logic [7:0]  ctl_data_in,   // Control byte
  input wire logic [1:0]  cnt_idx_in,    // Location
  input wire logic        cnt_rd_in,     // Read
  input wire logic        cnt_wr_in,     // Write
  input wire logic [47:0] count_in,      // Live counts
  input wire logic [2:0]  cnt_out_in,    // Output levels
  input wire logic [2:0]  null_count_in, // Null flags
  input wire logic [7:0]  rd_data_out,   // Read byte
  input wire logic [17:0] cfg_out,       // Config
  input wire logic [2:0]  ptr_hi_out     // Pointers
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // Control byte aimed at counter 0
  wire logic c0w = ctl_wr_in && ctl_data_in[7:6] == 2'h0;
  wire logic a0 = cnt_idx_in == 2'h0 && (cnt_rd_in || cnt_wr_in);
  AST_CFG_LOAD: assert property (c0w && ctl_data_in[5:4] != 2'h0
    |=> cfg_out[5:0] == $past(ctl_data_in[5:0])) else $error("config not stored");
  AST_LATCH_KEEPS_CFG: assert property (c0w && ctl_data_in[5:4] == 2'h0
    |=> $stable(cfg_out)) else $error("latch changed config");
  AST_CFG_STANDS: assert property (!ctl_wr_in |=> $stable(cfg_out))
    else $error("config moved");
  AST_PTR_RESTART: assert property (c0w && ctl_data_in[5:4] != 2'h0
    |=> !ptr_hi_out[0]) else $error("pointer not at low");
  AST_PTR_STILL: assert property (!ctl_wr_in && !a0 |=> $stable(ptr_hi_out[0]))
    else $error("pointer moved");
  AST_PTR_FLIP: assert property (!ctl_wr_in && !cnt_rd_in && a0 && cfg_out[5:4] == 2'h3
    |=> ptr_hi_out[0] != $past(ptr_hi_out[0])) else $error("pointer stuck");
  AST_RD_STANDS: assert property (!cnt_rd_in |=> $stable(rd_data_out))
    else $error("read byte moved");
  AST_UNMAPPED: assert property (cnt_rd_in && cnt_idx_in == 2'h3
    |=> rd_data_out == 8'h00) else $error("unmapped read");
  cover property (ctl_wr_in && ctl_data_in[7:6] == 2'h3);
  cover property (c0w && ctl_data_in[5:4] == 2'h0);
  cover property (ptr_hi_out[0] ##1 !ptr_hi_out[0]);
  cover property (cnt_rd_in && cnt_idx_in == 2'h3);
endmodule : clrb_top_properties
bind clrb_top clrb_top_properties clrb_top_properties_i (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .ctl_wr_in(ctl_wr_in), .ctl_data_in(ctl_data_in),
  .cnt_idx_in(cnt_idx_in), .cnt_rd_in(cnt_rd_in), .cnt_wr_in(cnt_wr_in), .count_in(count_in),
  .cnt_out_in(cnt_out_in), .null_count_in(null_count_in), .rd_data_out(rd_data_out),
  .cfg_out(cfg_out), .ptr_hi_out(ptr_hi_out));
`default_nettype wire
